// ==== design/blofc_top.sv ====
// black level and analog offset control registers behind a two-wire serial port
// assumes frame_start, settings_changed, gain_changed and sweep_done come from
// logic on ref_clk as one-cycle pulses
//
// Behaviour
// - control bit 0 set replaces automatic correction with programmed offsets
// - mode 00 calibrates during conversion, 10 continuously, x1 disables, offset zero
// - reserved bits 4-3 and 7 read one, 6-5 and 8 zero; host keeps them
// - bit 11 set keeps upper threshold after a sweep; clear resets it
// - writing one to bit 12 restarts the average and sweeps; self-clearing
// - bit 15 set, the reset state, skips the sweep on gain change
// - red offset: magnitude in bits 7-0, sign in bit 8
// - blue offset: magnitude in bits 7-0, sign in bit 8
// - sync register bit 0 is readout enable, bit 1 is update hold
// - clearing readout enable stops readout; setting restarts at next frame
// - with hold clear, brightness settings change at the next frame boundary
// - with hold set, pending brightness changes wait until hold clears
`timescale 1ns/100ps
module blofc_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic frame_start,
	input wire logic settings_changed,
	input wire logic gain_changed,
	input wire logic sweep_done,
	output logic manual_override,
	output logic cal_adc_only,
	output logic cal_continuous,
	output logic correction_off,
	output logic avg_restart,
	output logic sweep_start,
	output logic thres_hi_reset,
	output logic [8:0] red_offset,
	output logic [8:0] blue_offset,
	output logic readout_active,
	output logic row_restart,
	output logic apply_settings
);
	import blofc_pkg::*;

	typedef struct packed {
		logic manual;
		logic [1:0] cal;
		logic keep_thr;
		logic no_gain_sweep;
		logic [8:0] red_raw;
		logic [8:0] blue_raw;
		logic run;
		logic hold;
		logic pending;
		logic active;
		logic row_restart;
		logic apply;
		logic avg_restart;
		logic sweep_start;
		logic thres_hi_reset;
		logic adc_only;
		logic continuous;
		logic off;
		logic [8:0] red_eff;
		logic [8:0] blue_eff;
	} blofc_top_type;

	localparam blofc_top_type TOP_RESET = '{
		cal: BLOFC_CAL_RESET,
		no_gain_sweep: BLOFC_NO_GAIN_SWEEP_RESET,
		red_raw: BLOFC_OFFSET_RESET,
		blue_raw: BLOFC_OFFSET_RESET,
		run: BLOFC_RUN_RESET,
		adc_only: 1'b1,
		red_eff: BLOFC_OFFSET_RESET,
		blue_eff: BLOFC_OFFSET_RESET,
		default: '0
	};

	logic [1:0] rst_pipe_r;
	logic rst_sync_n;
	blofc_top_type s_r;
	blofc_top_type s_nxt;
	blofc_regbus_type bus;
	logic [15:0] rdata;
	logic restart_wr;

	// ************************************************************
	// reset release
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe_r <= 2'h0;
		else
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
	end

	assign rst_sync_n = rst_pipe_r[1];

	// ************************************************************
	// serial port
	// ************************************************************
	blofc_twi_slave u_twi (
		.ref_clk(ref_clk),
		.rst_sync_n(rst_sync_n),
		.scl(scl),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.bus(bus),
		.rdata(rdata)
	);

	// ************************************************************
	// read view
	// ************************************************************
	function automatic logic [15:0] read_reg(input logic [7:0] addr, input blofc_top_type st);
		logic [15:0] v;
		v = 16'h0000;
		case (addr)
			BLOFC_OFS_CTRL:
			begin
				v = BLOFC_CTRL_FIXED;
				v[BLOFC_BIT_MANUAL] = st.manual;
				v[BLOFC_BIT_CAL_HI:BLOFC_BIT_CAL_LO] = st.cal;
				v[BLOFC_BIT_KEEP_THR] = st.keep_thr;
				v[BLOFC_BIT_NO_GAIN_SWEEP] = st.no_gain_sweep;
			end
			BLOFC_OFS_RED:
				v[BLOFC_BIT_SIGN:0] = st.red_raw;
			BLOFC_OFS_BLUE:
				v[BLOFC_BIT_SIGN:0] = st.blue_raw;
			BLOFC_OFS_SYNC:
			begin
				v[BLOFC_BIT_RUN] = st.run;
				v[BLOFC_BIT_HOLD] = st.hold;
			end
			default:
				v = 16'h0000;
		endcase
		return v;
	endfunction : read_reg

	assign rdata = read_reg(bus.addr, s_r);

	// ************************************************************
	// register writes and control behaviour
	// ************************************************************
	always_comb
	begin
		s_nxt = s_r;
		restart_wr = 1'b0;
		s_nxt.row_restart = 1'b0;
		s_nxt.apply = 1'b0;
		if (bus.wr_stb)
		begin
			case (bus.addr)
				BLOFC_OFS_CTRL:
				begin
					s_nxt.manual = bus.wdata[BLOFC_BIT_MANUAL];
					s_nxt.cal = bus.wdata[BLOFC_BIT_CAL_HI:BLOFC_BIT_CAL_LO];
					s_nxt.keep_thr = bus.wdata[BLOFC_BIT_KEEP_THR];
					s_nxt.no_gain_sweep = bus.wdata[BLOFC_BIT_NO_GAIN_SWEEP];
					restart_wr = bus.wdata[BLOFC_BIT_RESTART];
				end
				BLOFC_OFS_RED:
					s_nxt.red_raw = bus.wdata[BLOFC_BIT_SIGN:0];
				BLOFC_OFS_BLUE:
					s_nxt.blue_raw = bus.wdata[BLOFC_BIT_SIGN:0];
				BLOFC_OFS_SYNC:
				begin
					s_nxt.run = bus.wdata[BLOFC_BIT_RUN];
					s_nxt.hold = bus.wdata[BLOFC_BIT_HOLD];
				end
				default:
					s_nxt.run = s_r.run;
			endcase
		end
		s_nxt.avg_restart = restart_wr;
		s_nxt.sweep_start = restart_wr | (gain_changed & ~s_r.no_gain_sweep);
		s_nxt.thres_hi_reset = sweep_done & ~s_r.keep_thr;
		s_nxt.off = s_r.cal[0];
		s_nxt.continuous = (s_r.cal == BLOFC_CAL_CONT);
		s_nxt.adc_only = (s_r.cal == BLOFC_CAL_RESET);
		s_nxt.red_eff = s_r.cal[0] ? BLOFC_OFFSET_RESET : s_r.red_raw;
		s_nxt.blue_eff = s_r.cal[0] ? BLOFC_OFFSET_RESET : s_r.blue_raw;
		if (!s_r.run)
			s_nxt.active = 1'b0;
		else if (!s_r.active && frame_start)
		begin
			s_nxt.active = 1'b1;
			s_nxt.row_restart = 1'b1;
		end
		if (settings_changed)
			s_nxt.pending = 1'b1;
		if (frame_start && !s_r.hold && (s_r.pending || settings_changed))
		begin
			s_nxt.apply = 1'b1;
			s_nxt.pending = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s_r <= TOP_RESET;
		else
			s_r <= s_nxt;
	end

	assign manual_override = s_r.manual;
	assign cal_adc_only = s_r.adc_only;
	assign cal_continuous = s_r.continuous;
	assign correction_off = s_r.off;
	assign avg_restart = s_r.avg_restart;
	assign sweep_start = s_r.sweep_start;
	assign thres_hi_reset = s_r.thres_hi_reset;
	assign red_offset = s_r.red_eff;
	assign blue_offset = s_r.blue_eff;
	assign readout_active = s_r.active;
	assign row_restart = s_r.row_restart;
	assign apply_settings = s_r.apply;

endmodule : blofc_top

// ==== common/blofc_pkg.sv ====
// constants and types of the black level and offset control register bank
// assumes one 200 MHz clock domain; pins of the two-wire port are asynchronous
package blofc_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] BLOFC_OFS_CTRL = 8'h62;
	localparam logic [7:0] BLOFC_OFS_RED = 8'h63;
	localparam logic [7:0] BLOFC_OFS_BLUE = 8'h64;
	localparam logic [7:0] BLOFC_OFS_SYNC = 8'hF1;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BLOFC_BIT_MANUAL = 0;
	localparam int BLOFC_BIT_CAL_LO = 1;
	localparam int BLOFC_BIT_CAL_HI = 2;
	localparam int BLOFC_BIT_KEEP_THR = 11;
	localparam int BLOFC_BIT_RESTART = 12;
	localparam int BLOFC_BIT_NO_GAIN_SWEEP = 15;
	localparam int BLOFC_BIT_SIGN = 8;
	localparam int BLOFC_BIT_RUN = 0;
	localparam int BLOFC_BIT_HOLD = 1;

	// ************************************************************
	// values after reset and fixed values
	// ************************************************************
	localparam logic [15:0] BLOFC_CTRL_FIXED = 16'h0098;
	localparam logic [1:0] BLOFC_CAL_RESET = 2'h0;
	localparam logic [1:0] BLOFC_CAL_CONT = 2'h2;
	localparam logic BLOFC_NO_GAIN_SWEEP_RESET = 1'b1;
	localparam logic [8:0] BLOFC_OFFSET_RESET = 9'h000;
	localparam logic BLOFC_RUN_RESET = 1'b1;
	localparam logic [6:0] BLOFC_DEV_ADDR = 7'h48;
	localparam logic [3:0] BLOFC_BYTE_BITS = 4'h8;
	localparam logic [3:0] BLOFC_LAST_TX = 4'h7;

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic wr_stb;
		logic [7:0] addr;
		logic [15:0] wdata;
	} blofc_regbus_type;

	typedef enum logic [3:0] {
		TW_IDLE = 4'h0,
		TW_DEV = 4'h1,
		TW_ACK_DEV = 4'h2,
		TW_REG = 4'h3,
		TW_ACK_REG = 4'h4,
		TW_WR = 4'h5,
		TW_ACK_WR = 4'h6,
		TW_RD = 4'h7,
		TW_RD_ACK = 4'h8
	} blofc_tw_state_type;

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		blofc_tw_state_type state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [7:0] hi;
		logic rw;
		logic lo;
		logic nack;
		logic oe;
		blofc_regbus_type bus;
	} blofc_twi_type;

endpackage : blofc_pkg

// ==== design/blofc_twi_slave.sv ====
// two-wire serial slave: 8-bit register address, 16-bit data, high byte first
// assumes an open-drain data pin and a host that drives the serial clock
`timescale 1ns/100ps
module blofc_twi_slave (
	input wire logic ref_clk,
	input wire logic rst_sync_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output blofc_pkg::blofc_regbus_type bus,
	input wire logic [15:0] rdata
);
	import blofc_pkg::*;

	blofc_twi_type s_r;
	blofc_twi_type s_nxt;
	logic scl_hi;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	// ************************************************************
	// pin edge detection on synchronised copies
	// ************************************************************
	always_comb
	begin
		scl_hi = s_r.scl_sync[1] & s_r.scl_prev;
		scl_rise = s_r.scl_sync[1] & ~s_r.scl_prev;
		scl_fall = ~s_r.scl_sync[1] & s_r.scl_prev;
		start_cond = scl_hi & s_r.sda_prev & ~s_r.sda_sync[1];
		stop_cond = scl_hi & ~s_r.sda_prev & s_r.sda_sync[1];
	end

	// ************************************************************
	// protocol engine
	// ************************************************************
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.scl_sync = {s_r.scl_sync[0], scl};
		s_nxt.sda_sync = {s_r.sda_sync[0], sda_in};
		s_nxt.scl_prev = s_r.scl_sync[1];
		s_nxt.sda_prev = s_r.sda_sync[1];
		s_nxt.bus.wr_stb = 1'b0;
		if (start_cond)
		begin
			s_nxt.state = TW_DEV;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end
		else if (stop_cond)
		begin
			s_nxt.state = TW_IDLE;
			s_nxt.oe = 1'b0;
		end
		else if (scl_rise)
		begin
			if (s_r.state == TW_DEV || s_r.state == TW_REG || s_r.state == TW_WR)
			begin
				s_nxt.shift = {s_r.shift[6:0], s_r.sda_sync[1]};
				s_nxt.cnt = s_r.cnt + 4'h1;
			end
			if (s_r.state == TW_RD_ACK)
				s_nxt.nack = s_r.sda_sync[1];
		end
		else if (scl_fall)
		begin
			case (s_r.state)
				TW_DEV:
					if (s_r.cnt == BLOFC_BYTE_BITS)
					begin
						if (s_r.shift[7:1] == BLOFC_DEV_ADDR)
						begin
							s_nxt.oe = 1'b1;
							s_nxt.rw = s_r.shift[0];
							s_nxt.state = TW_ACK_DEV;
						end
						else
							s_nxt.state = TW_IDLE;
					end
				TW_ACK_DEV:
					if (s_r.rw)
					begin
						s_nxt.tx = rdata[15:8];
						s_nxt.oe = ~rdata[15];
						s_nxt.lo = 1'b0;
						s_nxt.cnt = 4'h0;
						s_nxt.state = TW_RD;
					end
					else
					begin
						s_nxt.oe = 1'b0;
						s_nxt.cnt = 4'h0;
						s_nxt.state = TW_REG;
					end
				TW_REG:
					if (s_r.cnt == BLOFC_BYTE_BITS)
					begin
						s_nxt.bus.addr = s_r.shift;
						s_nxt.oe = 1'b1;
						s_nxt.state = TW_ACK_REG;
					end
				TW_ACK_REG:
				begin
					s_nxt.oe = 1'b0;
					s_nxt.cnt = 4'h0;
					s_nxt.lo = 1'b0;
					s_nxt.state = TW_WR;
				end
				TW_WR:
					if (s_r.cnt == BLOFC_BYTE_BITS)
					begin
						if (s_r.lo)
						begin
							s_nxt.bus.wr_stb = 1'b1;
							s_nxt.bus.wdata = {s_r.hi, s_r.shift};
						end
						else
							s_nxt.hi = s_r.shift;
						s_nxt.oe = 1'b1;
						s_nxt.state = TW_ACK_WR;
					end
				TW_ACK_WR:
				begin
					s_nxt.oe = 1'b0;
					s_nxt.cnt = 4'h0;
					s_nxt.lo = ~s_r.lo;
					if (s_r.lo)
						s_nxt.bus.addr = s_r.bus.addr + 8'h01;
					s_nxt.state = TW_WR;
				end
				TW_RD:
					if (s_r.cnt == BLOFC_LAST_TX)
					begin
						s_nxt.oe = 1'b0;
						s_nxt.state = TW_RD_ACK;
						// pointer moves on once the low byte is out, so the next high byte is fresh
						if (s_r.lo)
							s_nxt.bus.addr = s_r.bus.addr + 8'h01;
					end
					else
					begin
						s_nxt.tx = {s_r.tx[6:0], 1'b0};
						s_nxt.oe = ~s_r.tx[6];
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
				TW_RD_ACK:
					if (s_r.nack)
						s_nxt.state = TW_IDLE;
					else
					begin
						s_nxt.tx = s_r.lo ? rdata[15:8] : rdata[7:0];
						s_nxt.oe = s_r.lo ? ~rdata[15] : ~rdata[7];
						s_nxt.lo = ~s_r.lo;
						s_nxt.cnt = 4'h0;
						s_nxt.state = TW_RD;
					end
				default:
					s_nxt.state = TW_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s_r <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
				state: TW_IDLE, default: '0};
		else
			s_r <= s_nxt;
	end

	assign sda_out = 1'b0;
	assign sda_oe = s_r.oe;
	assign bus = s_r.bus;

endmodule : blofc_twi_slave

// ==== verif/blofc_checker.sv ====
// concurrent checks on the control outputs of the register bank
// assumes a bind into blofc_top; sees only its ports
`timescale 1ns/100ps
module blofc_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic frame_start,
	input wire logic sweep_done,
	input wire logic cal_adc_only,
	input wire logic cal_continuous,
	input wire logic correction_off,
	input wire logic avg_restart,
	input wire logic sweep_start,
	input wire logic thres_hi_reset,
	input wire logic [8:0] red_offset,
	input wire logic [8:0] blue_offset,
	input wire logic readout_active,
	input wire logic row_restart,
	input wire logic apply_settings
);
	// ********
	// assertions
	// ********
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	chk_cal_onehot: assert property ($onehot({cal_adc_only, cal_continuous, correction_off}))
		else $error("calibration mode outputs not one-hot");
	chk_off_zero: assert property (correction_off && $past(correction_off) |->
		red_offset == 9'h000 && blue_offset == 9'h000) else $error("offset not zero");
	chk_restart_pair: assert property (avg_restart |-> sweep_start)
		else $error("restart without sweep");
	chk_restart_pulse: assert property (avg_restart |=> !avg_restart)
		else $error("restart not self clearing");
	chk_thres_cause: assert property (thres_hi_reset |-> $past(sweep_done))
		else $error("threshold reset without sweep end");
	chk_apply_frame: assert property (apply_settings |-> $past(frame_start))
		else $error("settings applied off frame boundary");
	chk_row_frame: assert property (row_restart |-> $past(frame_start) && readout_active)
		else $error("row restart off frame boundary");
	chk_readout_rise: assert property ($rose(readout_active) |-> $past(frame_start))
		else $error("readout resumed mid frame");
	cov_restart: cover property (avg_restart);
	cov_apply: cover property (apply_settings);
	cov_row: cover property (row_restart);
endmodule : blofc_checker

// ==== verif/blofc_host.sv ====
// host model of the two-wire port: drives serial clock, open-drain data
// assumes a pull-up on data and a device that pulls low with sda_oe
`timescale 1ns/100ps
module blofc_host (
	input wire logic ref_clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_in
);
	import blofc_pkg::*;
	logic low;
	assign sda_in = !(low || sda_oe);
	initial
	begin
		scl = 1'b1;
		low = 1'b0;
	end
	task hp();
		repeat (10) @(posedge ref_clk);
		#1;
	endtask : hp
	task clk1(output logic b);
		hp();
		scl = 1'b1;
		hp();
		b = sda_in;
		scl = 1'b0;
	endtask : clk1
	task start();
		low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		low = 1'b1;
		hp();
		scl = 1'b0;
	endtask : start
	task stop();
		low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		low = 1'b0;
		hp();
	endtask : stop
	task wbyte(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			low = !v[i];
			clk1(b);
		end
		low = 1'b0;
		clk1(b);
		ack = !b;
	endtask : wbyte
	task rbyte(input logic last, output logic [7:0] v);
		logic b;
		low = 1'b0;
		for (int i = 7; i >= 0; i--)
			clk1(v[i]);
		low = !last;
		clk1(b);
		low = 1'b0;
	endtask : rbyte
	// whole word, high byte first, as the caller hands it
	task wr(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] d, output logic ok);
		logic k0, k1, k2, k3;
		start();
		wbyte({dev, 1'b0}, k0);
		wbyte(a, k1);
		wbyte(d[15:8], k2);
		wbyte(d[7:0], k3);
		stop();
		ok = k0 & k1 & k2 & k3;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		logic k;
		start();
		wbyte({BLOFC_DEV_ADDR, 1'b0}, k);
		wbyte(a, k);
		start();
		wbyte({BLOFC_DEV_ADDR, 1'b1}, k);
		rbyte(1'b0, d[15:8]);
		rbyte(1'b1, d[7:0]);
		stop();
	endtask : rd
	// two words in one read, the pointer moving on between them
	task rd2(input logic [7:0] a, output logic [15:0] d0, output logic [15:0] d1);
		logic k;
		start();
		wbyte({BLOFC_DEV_ADDR, 1'b0}, k);
		wbyte(a, k);
		start();
		wbyte({BLOFC_DEV_ADDR, 1'b1}, k);
		rbyte(1'b0, d0[15:8]);
		rbyte(1'b0, d0[7:0]);
		rbyte(1'b0, d1[15:8]);
		rbyte(1'b1, d1[7:0]);
		stop();
	endtask : rd2
endmodule : blofc_host

// ==== verif/blofc_tb.sv ====
// self-checking bench of the register bank through the two-wire host model
// assumes blofc_top, blofc_host and blofc_checker compiled before
`timescale 1ns/100ps
module blofc_tb;
	import blofc_pkg::*;
	logic ref_clk, rst_n, frame_start, settings_changed, gain_changed, sweep_done;
	logic scl, sda_in, sda_out, sda_oe, manual_override, cal_adc_only, cal_continuous;
	logic correction_off, avg_restart, sweep_start, thres_hi_reset, readout_active;
	logic row_restart, apply_settings, ok;
	logic [8:0] red_offset, blue_offset;
	logic [15:0] rv, rv2;
	int n_errors, checked, n_avg, n_swp, n_thr, n_app, n_row;
	blofc_top dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.scl(scl),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.frame_start(frame_start),
		.settings_changed(settings_changed),
		.gain_changed(gain_changed),
		.sweep_done(sweep_done),
		.manual_override(manual_override),
		.cal_adc_only(cal_adc_only),
		.cal_continuous(cal_continuous),
		.correction_off(correction_off),
		.avg_restart(avg_restart),
		.sweep_start(sweep_start),
		.thres_hi_reset(thres_hi_reset),
		.red_offset(red_offset),
		.blue_offset(blue_offset),
		.readout_active(readout_active),
		.row_restart(row_restart),
		.apply_settings(apply_settings)
	);
	blofc_host host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ********
	// pulse counters and tasks
	// ********
	always @(posedge ref_clk)
	begin
		if (avg_restart === 1'b1) n_avg++;
		if (sweep_start === 1'b1) n_swp++;
		if (thres_hi_reset === 1'b1) n_thr++;
		if (apply_settings === 1'b1) n_app++;
		if (row_restart === 1'b1) n_row++;
	end
	task give_verdict();
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task ev(input logic [3:0] m);
		{frame_start, settings_changed, gain_changed, sweep_done} = m;
		@(posedge ref_clk);
		#1;
		{frame_start, settings_changed, gain_changed, sweep_done} = 4'h0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : ev
	task w(input logic [7:0] a, input logic [15:0] d);
		host.wr(BLOFC_DEV_ADDR, a, d, ok);
		chk(ok, 16'h0001);
	endtask : w
	task r(input logic [7:0] a, input logic [15:0] exp);
		host.rd(a, rv);
		chk(rv, exp);
	endtask : r
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		n_errors++;
		$display("CHECK FAILED at %0t: timeout", $time);
		give_verdict();
	end
	// ********
	// main sequence
	// ********
	initial
	begin
		rst_n = 1'b0;
		{frame_start, settings_changed, gain_changed, sweep_done} = 4'h0;
		repeat (12) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		r(BLOFC_OFS_CTRL, 16'h8098);
		r(BLOFC_OFS_RED, 16'h0000);
		r(BLOFC_OFS_BLUE, 16'h0000);
		r(BLOFC_OFS_SYNC, 16'h0001);
		chk(cal_adc_only, 16'h0001);
		chk(manual_override, 16'h0000);
		ev(4'h8);
		chk(readout_active, 16'h0001);
		w(BLOFC_OFS_CTRL, 16'h9E9F);
		chk(n_avg, 16'h0001);
		chk(n_swp, 16'h0001);
		chk(manual_override, 16'h0001);
		r(BLOFC_OFS_CTRL, 16'h889F);
		w(BLOFC_OFS_RED, 16'h01A5);
		w(BLOFC_OFS_BLUE, 16'h0042);
		r(BLOFC_OFS_RED, 16'h01A5);
		r(BLOFC_OFS_BLUE, 16'h0042);
		host.rd2(BLOFC_OFS_RED, rv, rv2);
		chk(rv, 16'h01A5);
		chk(rv2, 16'h0042);
		for (int m = 0; m < 4; m++)
		begin
			w(BLOFC_OFS_CTRL, 16'h8098 | 16'(m << 1));
			chk(cal_adc_only, 16'(m == 0));
			chk(cal_continuous, 16'(m == 2));
			chk(correction_off, 16'(m % 2 == 1));
			chk(red_offset, (m % 2 == 1) ? 16'h0000 : 16'h01A5);
			chk(blue_offset, (m % 2 == 1) ? 16'h0000 : 16'h0042);
		end
		ev(4'h1);
		chk(n_thr, 16'h0001);
		w(BLOFC_OFS_CTRL, 16'h8898);
		ev(4'h1);
		chk(n_thr, 16'h0001);
		ev(4'h2);
		chk(n_swp, 16'h0001);
		w(BLOFC_OFS_CTRL, 16'h0098);
		ev(4'h2);
		chk(n_swp, 16'h0002);
		w(BLOFC_OFS_SYNC, 16'h0000);
		chk(readout_active, 16'h0000);
		w(BLOFC_OFS_SYNC, 16'h0001);
		chk(readout_active, 16'h0000);
		ev(4'h8);
		chk(readout_active, 16'h0001);
		chk(n_row, 16'h0002);
		w(BLOFC_OFS_SYNC, 16'h0003);
		ev(4'h4);
		ev(4'h8);
		chk(n_app, 16'h0000);
		r(BLOFC_OFS_SYNC, 16'h0003);
		w(BLOFC_OFS_SYNC, 16'h0001);
		ev(4'h8);
		chk(n_app, 16'h0001);
		ev(4'hC);
		chk(n_app, 16'h0002);
		r(8'h70, 16'h0000);
		host.wr(7'h49, BLOFC_OFS_CTRL, 16'h8099, ok);
		chk(ok, 16'h0000);
		r(BLOFC_OFS_CTRL, 16'h0098);
		chk(sda_out, 16'h0000);
		give_verdict();
	end
endmodule : blofc_tb
bind blofc_top blofc_checker u_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.frame_start(frame_start),
	.sweep_done(sweep_done),
	.cal_adc_only(cal_adc_only),
	.cal_continuous(cal_continuous),
	.correction_off(correction_off),
	.avg_restart(avg_restart),
	.sweep_start(sweep_start),
	.thres_hi_reset(thres_hi_reset),
	.red_offset(red_offset),
	.blue_offset(blue_offset),
	.readout_active(readout_active),
	.row_restart(row_restart),
	.apply_settings(apply_settings)
);
